// [core/ffla_pkg.sv]
// package for the flip-flop and latch array: element kinds, input bundle
// field positions, reset values and clock-to-output timing.
// assumes a single 250 MHz reference clock drives every register.
package ffla_pkg;

  // ----------------------------------------------------------------
  // element kinds
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FFLA_KIND_JK  = 4'h1,   // falling_edge_jk_store
    FFLA_KIND_D   = 4'h2,   // rising_edge_data_store
    FFLA_KIND_SRL = 4'h4,   // gated_set_reset_latch
    FFLA_KIND_DL  = 4'h8    // gated_data_latch
  } ffla_kind_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int FFLA_CLK_PERIOD_PS = 4000;
  localparam int FFLA_CLK_Q_PS      = 8000;
  // least time, rounded up to whole cycles, never below one
  localparam int FFLA_CLK_Q_CYC_RAW =
    (FFLA_CLK_Q_PS + FFLA_CLK_PERIOD_PS - 1) / FFLA_CLK_PERIOD_PS;
  localparam int FFLA_CLK_Q_CYC =
    (FFLA_CLK_Q_CYC_RAW < 1) ? 1 : FFLA_CLK_Q_CYC_RAW;

  // ----------------------------------------------------------------
  // defaults and input bundle layout
  // ----------------------------------------------------------------
  localparam int FFLA_NUM_ELEMS   = 1;
  localparam int FFLA_POWER_ON    = 0;
  localparam int FFLA_SYNC_CLK    = 0;
  localparam int FFLA_SYNC_PRE    = 1;
  localparam int FFLA_SYNC_CLR    = 2;
  localparam int FFLA_SYNC_PRE_X  = 3;
  localparam int FFLA_SYNC_CLR_X  = 4;
  localparam int FFLA_SYNC_DATA   = 5;
  // controls idle at reset: clock low, preset and clear inactive high
  localparam logic [4:0] FFLA_SYNC_CTL_RST = 5'h06;

endpackage

// [core/ffla_in_if.sv]
// interface carrying the synchronised inputs from the input stage to
// the storage array.
// assumes both ends run on ref_clk.
`timescale 1ns/1ps

interface ffla_in_if #(
  parameter int N = 1
);
  logic         clk_lvl;
  logic         clk_rise;
  logic         clk_fall;
  logic         preset_n;
  logic         clear_n;
  logic         preset_x;
  logic         clear_x;
  logic [N-1:0] data_a;
  logic [N-1:0] data_b;

  modport src (
    output clk_lvl, clk_rise, clk_fall, preset_n, clear_n,
           preset_x, clear_x, data_a, data_b
  );
  modport dst (
    input  clk_lvl, clk_rise, clk_fall, preset_n, clear_n,
           preset_x, clear_x, data_a, data_b
  );
endinterface

// [core/ffla_in_sync.sv]
// input stage: two-flop synchronisers for every pin and edge detection
// of the shared clock or gate pin.
// assumes all pins are asynchronous to ref_clk.
`timescale 1ns/1ps

module ffla_in_sync #(
  parameter int N = ffla_pkg::FFLA_NUM_ELEMS
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         clk_gate_pin,
  input  wire logic         preset_n_pin,
  input  wire logic         clear_n_pin,
  input  wire logic         preset_x_pin,
  input  wire logic         clear_x_pin,
  input  wire logic [N-1:0] data_a_pin,
  input  wire logic [N-1:0] data_b_pin,
  ffla_in_if.src            sync_o
);
  import ffla_pkg::*;

  localparam int W = FFLA_SYNC_DATA + 2 * N;
  localparam logic [W-1:0] RST_VAL =
    {{(2 * N){1'b0}}, FFLA_SYNC_CTL_RST};

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [W-1:0] raw;
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic         lvl3_r;

  assign raw = {data_b_pin, data_a_pin, clear_x_pin, preset_x_pin,
                clear_n_pin, preset_n_pin, clk_gate_pin};

  // s1_r feeds s2_r only; edges are taken from s2_r against lvl3_r
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_r   <= RST_VAL;
      s2_r   <= RST_VAL;
      lvl3_r <= 1'b0;
    end else begin
      s1_r   <= raw;
      s2_r   <= s1_r;
      lvl3_r <= s2_r[FFLA_SYNC_CLK];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sync_o.clk_lvl  = s2_r[FFLA_SYNC_CLK];
  assign sync_o.clk_rise = s2_r[FFLA_SYNC_CLK] & ~lvl3_r;
  assign sync_o.clk_fall = ~s2_r[FFLA_SYNC_CLK] & lvl3_r;
  assign sync_o.preset_n = s2_r[FFLA_SYNC_PRE];
  assign sync_o.clear_n  = s2_r[FFLA_SYNC_CLR];
  assign sync_o.preset_x = s2_r[FFLA_SYNC_PRE_X];
  assign sync_o.clear_x  = s2_r[FFLA_SYNC_CLR_X];
  assign sync_o.data_a   = s2_r[FFLA_SYNC_DATA +: N];
  assign sync_o.data_b   = s2_r[FFLA_SYNC_DATA + N +: N];

endmodule // ffla_in_sync

// [core/ffla_flip_flop_latch_array.sv]
// storage array of one element kind: falling-edge jk, rising-edge d,
// gated set-reset latch or gated data latch, with shared preset, clear
// and clock or gate.
// assumes pins are asynchronous; they pass the input stage first.
`timescale 1ns/1ps

// Overview of operation
// - the jk kind changes state only on a falling edge of the clock.
// - the d kind changes state only on a rising edge of the clock.
// - both latch kinds follow their inputs while the gate is high.
// - edge kinds show a new state a set delay after the edge.
// - element count is a parameter; controls are shared by all.
// - the true output powers up at the power-on level, else unknown.
// - an unknown input whose every value gives one result is harmless.
// - preset low forces 1, clear low forces 0, both low is unknown.
// - jk holds on 00, resets on 01, sets on 10, toggles on 11.
// - the d kind loads its data input on a rising edge and else holds.
// - the set-reset latch holds, resets, sets; 11 gives unknown.
// - the data latch copies data while gate is high, else holds.
module ffla_flip_flop_latch_array #(
  parameter int                   N         = ffla_pkg::FFLA_NUM_ELEMS,
  parameter ffla_pkg::ffla_kind_t ELEM_KIND = ffla_pkg::FFLA_KIND_JK,
  parameter int power_on_level_setting      = ffla_pkg::FFLA_POWER_ON,
  parameter int DELAY_CYC                   = ffla_pkg::FFLA_CLK_Q_CYC
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         clk_gate_pin,
  input  wire logic         preset_n,
  input  wire logic         clear_n,
  input  wire logic         preset_unknown,
  input  wire logic         clear_unknown,
  input  wire logic [N-1:0] data_a,
  input  wire logic [N-1:0] data_b,
  output logic      [N-1:0] true_out,
  output logic      [N-1:0] inverted_output,
  output logic      [N-1:0] out_unknown
);
  import ffla_pkg::*;

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam int CW = $clog2(DELAY_CYC + 1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(DELAY_CYC);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);
  localparam logic [CW-1:0] CNT_ZERO = CW'(0);
  localparam logic IS_JK  = (ELEM_KIND == FFLA_KIND_JK);
  localparam logic IS_D   = (ELEM_KIND == FFLA_KIND_D);
  localparam logic IS_SRL = (ELEM_KIND == FFLA_KIND_SRL);
  localparam logic IS_EDGE = IS_JK | IS_D;
  localparam logic [N-1:0] POR_VAL = {N{power_on_level_setting == 1}};
  localparam logic [N-1:0] POR_UNK =
    {N{(power_on_level_setting != 0) && (power_on_level_setting != 1)}};

  // ----------------------------------------------------------------
  // input stage
  // ----------------------------------------------------------------
  ffla_in_if #(.N(N)) in_bus ();

  ffla_in_sync #(.N(N)) u_sync (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .clk_gate_pin (clk_gate_pin),
    .preset_n_pin (preset_n),
    .clear_n_pin  (clear_n),
    .preset_x_pin (preset_unknown),
    .clear_x_pin  (clear_unknown),
    .data_a_pin   (data_a),
    .data_b_pin   (data_b),
    .sync_o       (in_bus.src)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [N-1:0]  q_r;
  logic [N-1:0]  qb_r;
  logic [N-1:0]  qx_r;
  logic [N-1:0]  pend_val_r;
  logic [N-1:0]  pend_unk_r;
  logic [CW-1:0] cnt_r;
  logic [N-1:0]  q_nxt;
  logic [N-1:0]  qx_nxt;
  logic [N-1:0]  pend_val_nxt;
  logic [N-1:0]  pend_unk_nxt;
  logic [CW-1:0] cnt_nxt;

  // ----------------------------------------------------------------
  // edge kinds: capture at the active edge, show after the delay
  // ----------------------------------------------------------------
  wire           act_edge;
  wire           force_any;
  wire           load;
  wire           pending;
  wire           apply;
  wire [N-1:0]   base_val;
  wire [N-1:0]   base_unk;
  wire [N-1:0]   jk_val;
  wire [N-1:0]   jk_unk;
  wire [N-1:0]   edge_val;
  wire [N-1:0]   edge_unk;
  wire [N-1:0]   ja;
  wire [N-1:0]   kb;

  assign ja = in_bus.data_a;
  assign kb = in_bus.data_b;
  // one shared clock edge steps every element of the array
  assign act_edge = (IS_JK & in_bus.clk_fall)
                  | (IS_D & in_bus.clk_rise);
  // an unknown preset or clear counts as a possible force
  assign force_any = ~in_bus.preset_n | ~in_bus.clear_n
                   | in_bus.preset_x | in_bus.clear_x;
  assign load    = IS_EDGE & act_edge & ~force_any;
  assign pending = (cnt_r != CNT_ZERO);
  assign apply   = (cnt_r == CNT_ONE);
  // an edge inside the delay builds on the state still in flight
  assign base_val = pending ? pend_val_r : q_r;
  assign base_unk = pending ? pend_unk_r : qx_r;
  // hold 00, reset 01, set 10, toggle 11
  assign jk_val = (ja & ~base_val) | (~kb & base_val);
  assign jk_unk = base_unk & ~(ja ^ kb);
  assign edge_val = IS_JK ? jk_val : ja;
  assign edge_unk = IS_JK ? jk_unk : {N{1'b0}};

  assign pend_val_nxt = load ? edge_val : pend_val_r;
  assign pend_unk_nxt = load ? edge_unk : pend_unk_r;
  // a force cancels a change still in flight
  assign cnt_nxt = force_any ? CNT_ZERO
                 : load      ? CNT_LOAD
                 : pending   ? cnt_r - CNT_ONE
                 : CNT_ZERO;

  // ----------------------------------------------------------------
  // latch kinds and the unforced next state
  // ----------------------------------------------------------------
  wire [N-1:0] sr_val;
  wire [N-1:0] sr_unk;
  wire [N-1:0] lat_val;
  wire [N-1:0] lat_unk;
  wire [N-1:0] nrm_val;
  wire [N-1:0] nrm_unk;

  // hold 00, reset 01, set 10, unknown 11
  assign sr_val = (ja & ~kb) | (~ja & ~kb & q_r);
  assign sr_unk = (ja & kb) | (~ja & ~kb & qx_r);
  assign lat_val = IS_SRL ? sr_val : ja;
  assign lat_unk = IS_SRL ? sr_unk : {N{1'b0}};
  assign nrm_val = IS_EDGE ? (apply ? pend_val_r : q_r)
                 : (in_bus.clk_lvl ? lat_val : q_r);
  assign nrm_unk = IS_EDGE ? (apply ? pend_unk_r : qx_r)
                 : (in_bus.clk_lvl ? lat_unk : qx_r);

  // ----------------------------------------------------------------
  // preset and clear, resolved over every value an unknown may take
  // ----------------------------------------------------------------
  wire p_hi;
  wire p_lo;
  wire c_hi;
  wire c_lo;
  wire a11;
  wire a10;
  wire a01;
  wire a00;
  wire [N-1:0] any_one;
  wire [N-1:0] any_zero;
  wire [N-1:0] any_unk;

  assign p_hi = in_bus.preset_x | in_bus.preset_n;
  assign p_lo = in_bus.preset_x | ~in_bus.preset_n;
  assign c_hi = in_bus.clear_x | in_bus.clear_n;
  assign c_lo = in_bus.clear_x | ~in_bus.clear_n;
  assign a11 = p_hi & c_hi;
  assign a10 = p_hi & c_lo;
  assign a01 = p_lo & c_hi;
  assign a00 = p_lo & c_lo;
  assign any_one  = {N{a01}} | ({N{a11}} & nrm_val & ~nrm_unk);
  assign any_zero = {N{a10}} | ({N{a11}} & ~nrm_val & ~nrm_unk);
  assign any_unk  = {N{a00}} | ({N{a11}} & nrm_unk);
  // unknown only when the possible outcomes disagree
  assign qx_nxt = any_unk | (any_one & any_zero);
  assign q_nxt  = any_one & ~qx_nxt;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q_r        <= POR_VAL;
      qb_r       <= ~POR_VAL;
      qx_r       <= POR_UNK;
      pend_val_r <= {N{1'b0}};
      pend_unk_r <= {N{1'b0}};
      cnt_r      <= CNT_ZERO;
    end else begin
      q_r        <= q_nxt;
      qb_r       <= ~q_nxt;
      qx_r       <= qx_nxt;
      pend_val_r <= pend_val_nxt;
      pend_unk_r <= pend_unk_nxt;
      cnt_r      <= cnt_nxt;
    end
  end

  assign true_out        = q_r;
  assign inverted_output = qb_r;
  assign out_unknown     = qx_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_edge_load;
    load;
  endsequence

  sequence s_count_full;
    cnt_r == CNT_LOAD;
  endsequence

  sequence s_apply_clean;
    apply && !force_any;
  endsequence

  a_jk_fall_only: assert property (
    (IS_JK && load) |-> (in_bus.clk_fall && !in_bus.clk_rise))
    else $error("jk element loaded without a falling edge");

  a_d_rise_only: assert property (
    (IS_D && load) |-> (in_bus.clk_rise && !in_bus.clk_fall))
    else $error("d element loaded without a rising edge");

  a_delay_start: assert property (
    s_edge_load |=> s_count_full)
    else $error("delay counter not loaded at active edge");

  a_not_at_edge: assert property (
    (DELAY_CYC > 1 && load && !pending) |=>
      (q_r == $past(q_r) && qx_r == $past(qx_r)))
    else $error("edge element output changed at the edge");

  a_delayed_show: assert property (
    s_apply_clean |=>
      (q_r == ($past(pend_val_r) & ~$past(pend_unk_r)) &&
       qx_r == $past(pend_unk_r)))
    else $error("pending state not shown when delay ran out");

  a_power_on: assert property (
    $past(rst) |-> (q_r == POR_VAL && qx_r == POR_UNK))
    else $error("output after reset differs from power-on level");

  a_x_clear_zero: assert property (
    (in_bus.clear_x && in_bus.preset_n && !in_bus.preset_x &&
     nrm_val == '0 && nrm_unk == '0) |=>
      (q_r == '0 && qx_r == '0))
    else $error("unknown clear spoiled an output already zero");

  a_preset_force: assert property (
    (!in_bus.preset_n && in_bus.clear_n &&
     !in_bus.preset_x && !in_bus.clear_x) |=>
      (q_r == '1 && qx_r == '0 && cnt_r == CNT_ZERO))
    else $error("preset did not force ones");

  a_clear_force: assert property (
    (in_bus.preset_n && !in_bus.clear_n &&
     !in_bus.preset_x && !in_bus.clear_x) |=>
      (q_r == '0 && qx_r == '0 && cnt_r == CNT_ZERO))
    else $error("clear did not force zeros");

  a_both_low_unk: assert property (
    (!in_bus.preset_n && !in_bus.clear_n) |=> (qx_r == '1))
    else $error("preset and clear low together not unknown");

  a_jk_toggle: assert property (
    (IS_JK && load && !pending && ja == '1 && kb == '1) |=>
      (pend_val_r == ~$past(q_r)))
    else $error("jk element did not toggle on 11");

  a_d_capture: assert property (
    (IS_D && load) |=> (pend_val_r == $past(ja) && pend_unk_r == '0))
    else $error("d element did not capture data on rising edge");

  a_sr_both_unk: assert property (
    (IS_SRL && in_bus.clk_lvl && !force_any && (ja & kb) != '0) |=>
      ((qx_r & $past(ja & kb)) == $past(ja & kb)))
    else $error("set and reset high together not unknown");

  a_latch_follow: assert property (
    (ELEM_KIND == FFLA_KIND_DL && in_bus.clk_lvl && !force_any) |=>
      (q_r == $past(ja) && qx_r == '0))
    else $error("data latch not transparent while gate high");

  a_latch_hold: assert property (
    (!IS_EDGE && !in_bus.clk_lvl && !force_any) |=>
      (q_r == $past(q_r) && qx_r == $past(qx_r)))
    else $error("latch changed while gate low");

  a_inverted_comp: assert property (
    inverted_output == ~true_out)
    else $error("inverted output not complement of true output");

endmodule // ffla_flip_flop_latch_array

// [testbench/ffla_pin_drv.sv]
// pin driver standing in for the logic around the storage array.
// assumes the bench calls its tasks; pins move on falling ref_clk.
`timescale 1ns/1ps

module ffla_pin_drv #(
  parameter int N = 2
) (
  input  wire logic         ref_clk,
  output logic              clk_gate_pin,
  output logic              preset_n,
  output logic              clear_n,
  output logic              preset_unknown,
  output logic              clear_unknown,
  output logic      [N-1:0] data_a,
  output logic      [N-1:0] data_b
);
  initial begin
    clk_gate_pin   = 1'b0;
    preset_n       = 1'b1;
    clear_n        = 1'b1;
    preset_unknown = 1'b0;
    clear_unknown  = 1'b0;
    data_a         = '0;
    data_b         = '0;
  end

  // both controls low only when a test asks for that bad state
  task automatic set_ctl(input logic p, c, px, cx, bad);
    @(negedge ref_clk);
    if (!p && !c && !bad) begin
      c = 1'b1;
    end
    preset_n       = p;
    clear_n        = c;
    preset_unknown = px;
    clear_unknown  = cx;
  endtask

  task automatic set_data(input logic [N-1:0] a, b);
    @(negedge ref_clk);
    data_a = a;
    data_b = b;
  endtask

  // callers hold each level at least 8 cycles, well over the 5 needed
  task automatic set_gate(input logic lvl);
    @(negedge ref_clk);
    clk_gate_pin = lvl;
  endtask
endmodule // ffla_pin_drv

// [testbench/test_ffla_flip_flop_latch_array.sv]
// self-checking bench: one array of each kind on shared pins.
// assumes the pin driver model and a 250 MHz ref_clk.
`timescale 1ns/1ps

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end

module test_ffla_flip_flop_latch_array;
  import ffla_pkg::*;
  localparam ffla_kind_t KIND [4] = '{FFLA_KIND_JK, FFLA_KIND_D,
                                      FFLA_KIND_SRL, FFLA_KIND_DL};
  localparam int         PON  [4] = '{0, 1, 0, 2};
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       gate, pre_n, clr_n, pre_x, clr_x;
  logic [1:0] da, db;
  logic [1:0] q  [4];
  logic [1:0] qb [4];
  logic [1:0] xu [4];
  logic [1:0] e  [4];
  logic [1:0] eu [4];
  int         fails = 0;
  int         num_checks = 0;

  always #2 ref_clk = ~ref_clk;

  ffla_pin_drv i_drv (
    .ref_clk(ref_clk), .clk_gate_pin(gate), .preset_n(pre_n),
    .clear_n(clr_n), .preset_unknown(pre_x), .clear_unknown(clr_x),
    .data_a(da), .data_b(db)
  );

  // index 0 jk, 1 d, 2 set-reset latch, 3 data latch
  for (genvar g = 0; g < 4; g++) begin : g_kind
    ffla_flip_flop_latch_array #(
      .N(2), .ELEM_KIND(KIND[g]), .power_on_level_setting(PON[g])
    ) i_dut (
      .ref_clk(ref_clk), .rst(rst), .clk_gate_pin(gate),
      .preset_n(pre_n), .clear_n(clr_n), .preset_unknown(pre_x),
      .clear_unknown(clr_x), .data_a(da), .data_b(db),
      .true_out(q[g]), .inverted_output(qb[g]), .out_unknown(xu[g])
    );
  end

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic set_all(input logic [1:0] v, u);
    for (int k = 0; k < 4; k++) begin
      e[k]  = v;
      eu[k] = u;
    end
  endtask

  // true level is meaningless where unknown, so it is masked there
  task automatic check_all();
    for (int k = 0; k < 4; k++) begin
      `CHK(xu[k], eu[k])
      `CHK(q[k] & ~eu[k], e[k] & ~eu[k])
      `CHK(qb[k] & ~eu[k], ~e[k] & ~eu[k])
    end
  endtask

  task automatic latch(input logic [1:0] a, b);
    e[3]  = a;
    eu[3] = 2'h0;
    for (int i = 0; i < 2; i++) begin
      if (a[i] && b[i]) begin
        eu[2][i] = 1'b1;
      end else if (a[i] || b[i]) begin
        e[2][i]  = a[i];
        eu[2][i] = 1'b0;
      end
    end
  endtask

  task automatic rise(input logic [1:0] a, b);
    e[1]  = a;
    eu[1] = 2'h0;
    latch(a, b);
  endtask

  task automatic fall(input logic [1:0] a, b);
    for (int i = 0; i < 2; i++) begin
      if (a[i] && b[i]) begin
        e[0][i] = ~e[0][i];
      end else if (a[i] || b[i]) begin
        e[0][i] = a[i];
      end
    end
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  task automatic t_power_on();
    set_all(2'h0, 2'h0);
    e[1]  = 2'h3;
    eu[3] = 2'h3;
    check_all();
    $display("test power_on done");
  endtask

  task automatic t_force();
    i_drv.set_ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    wt(8);
    set_all(2'h0, 2'h3);
    check_all();
    i_drv.set_ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    wt(8);
    set_all(2'h0, 2'h0);
    check_all();
    i_drv.set_ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    wt(8);
    check_all();
    i_drv.set_ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    wt(8);
    set_all(2'h0, 2'h3);
    check_all();
    i_drv.set_ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    i_drv.set_gate(1'b1);
    wt(8);
    i_drv.set_gate(1'b0);
    wt(8);
    set_all(2'h3, 2'h0);
    check_all();
    i_drv.set_ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    wt(8);
    check_all();
    $display("test force done");
  endtask

  task automatic t_edges();
    logic [1:0] ja [4] = '{2'h2, 2'h0, 2'h3, 2'h1};
    logic [1:0] kb [4] = '{2'h1, 2'h0, 2'h3, 2'h2};
    for (int s = 0; s < 4; s++) begin
      i_drv.set_data(ja[s], kb[s]);
      wt(8);
      check_all();
      i_drv.set_gate(1'b1);
      wt(2);
      check_all();
      wt(6);
      rise(ja[s], kb[s]);
      check_all();
      i_drv.set_gate(1'b0);
      wt(2);
      check_all();
      wt(6);
      fall(ja[s], kb[s]);
      check_all();
    end
    $display("test edges done");
  endtask

  task automatic t_latch();
    logic [1:0] la [2] = '{2'h2, 2'h0};
    logic [1:0] lb [2] = '{2'h1, 2'h0};
    i_drv.set_gate(1'b1);
    wt(8);
    rise(2'h1, 2'h2);
    check_all();
    for (int s = 0; s < 2; s++) begin
      i_drv.set_data(la[s], lb[s]);
      wt(8);
      latch(la[s], lb[s]);
      check_all();
    end
    i_drv.set_gate(1'b0);
    wt(8);
    fall(2'h0, 2'h0);
    check_all();
    i_drv.set_data(2'h3, 2'h3);
    wt(8);
    check_all();
    $display("test latch done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    wt(4);
    t_power_on();
    t_force();
    t_edges();
    t_latch();
    end_sim();
  end

  // the tests need about 230 cycles
  initial begin
    repeat (2000) @(posedge ref_clk);
    fails++;
    end_sim();
  end
endmodule // test_ffla_flip_flop_latch_array
